// >>> core/fsbc_cpu.sv
// Processor end: request issue, parity, bus init and stall handling
module fsbc_cpu
  import fsbc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  fsbc_if.cpu bus,
  input wire logic bus_initialization_drv_en,
  input wire logic bus_initialization_obs_en,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [REQ_W-1:0] req_type,
  input wire logic busy,
  input wire logic fault,
  input wire logic [BPM_W-1:0] bpm_status,
  input wire logic probe_ready,
  output logic running,
  output logic bus_lock_r,
  output logic [3:0] ioq_count_r,
  output logic bus_initialization_seen
);
  fsbc_state_t st_r, st_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [REQ_W-1:0] req_r;
  logic [1:0] ap_r;
  logic adsv_r;
  logic sub2_r;
  logic [BPM_W-1:0] bpm_r;
  logic fault_r;
  logic drv_cfg_r;
  logic obs_cfg_r;
  logic cfg_done_r;

  // Power-on straps caught after reset release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_done_r <= 1'b0;
      drv_cfg_r <= 1'b0;
      obs_cfg_r <= 1'b0;
    end else if (!cfg_done_r) begin
      cfg_done_r <= 1'b1;
      drv_cfg_r <= bus_initialization_drv_en;
      obs_cfg_r <= bus_initialization_obs_en;
    end
  end

  assign running = bus.platform_select & cfg_done_r;
  assign bus_initialization_seen = obs_cfg_r & ~bus.bus_initialization_n;
  wire stalled = ~bus.bnr_n;
  assign req_ready = running & (st_r == FSBC_IDLE) & ~stalled & ~bus_initialization_seen;
  wire issue = req_valid & req_ready;

  // Request state: strobe with subphase one, then subphase two
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      FSBC_IDLE: if (issue) st_nxt = FSBC_REQ;
      FSBC_REQ: st_nxt = FSBC_SUB2;
      FSBC_SUB2: st_nxt = FSBC_IDLE;
      default: st_nxt = FSBC_IDLE;
    endcase
    if (bus_initialization_seen) st_nxt = FSBC_IDLE; // arbitration reset, re-arbitrate
  end

  // Drives request lines with parity, all on clk
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= FSBC_IDLE;
      addr_r <= '1;
      req_r <= '1;
      ap_r <= AP_RESET;
      adsv_r <= 1'b1;
      sub2_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      adsv_r <= ~issue;
      sub2_r <= (st_nxt == FSBC_SUB2);
      if (issue) begin
        addr_r <= ~req_addr;
        req_r <= ~req_type;
        ap_r <= fsbc_ap(~req_addr, ~req_type, 1'b0);
      end else if (st_nxt == FSBC_SUB2) begin
        ap_r <= fsbc_ap(addr_r, req_r, 1'b1);
      end else begin
        ap_r <= AP_RESET;
      end
    end
  end

  // Lock tracking reset by init; queue kept intact
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_lock_r <= LOCK_RESET;
      ioq_count_r <= '0;
    end else begin
      if (bus_initialization_seen) bus_lock_r <= LOCK_RESET;
      else if (issue) bus_lock_r <= req_type[0];
      if (issue) ioq_count_r <= ioq_count_r + 4'h1;
    end
  end

  // Fault latch and monitor outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_r <= 1'b0;
      bpm_r <= '1;
    end else begin
      fault_r <= fault & drv_cfg_r;
      bpm_r <= ~bpm_status;
      bpm_r[PROBE_READY_BIT] <= ~probe_ready;
    end
  end

  assign bus.adsv_n = adsv_r;
  assign bus.sub2 = sub2_r;
  assign bus.addr_n = addr_r;
  assign bus.req_n = req_r;
  assign bus.ap_n = ap_r;
  assign bus.bus_initialization_o_cpu = 1'b0;
  assign bus.bus_initialization_oe_cpu = fault_r;
  assign bus.bnr_o_cpu = 1'b0;
  assign bus.bnr_oe_cpu = busy & running;
  assign bus.bpm_n = bpm_r;
endmodule

// >>> core/fsbc_pkg.sv
// Shared constants and types for the front-side-bus control ends
// Overview of operation
// - Parity high when even count of lows
// - Checking starts on address strobe valid
// - All agents run on one bus clock
// - Bus init driven and sampled by all
// - Enabled driver asserts init on bus fault
// - Observed init resets lock and arbitration
// - In-order queue survives bus init
// - After init, re-arbitrate and finish queue; the code only keeps ioq_count_r and never drains it
// - Central agent handles init when unobserved
// - Busy agent asserts block next request
// - Owner issues nothing while bus stalled
// - No operation while platform select low; processor still drives init on fault and monitor lines
// - Six breakpoint monitor outputs driven
// - Monitor line four is probe ready
package fsbc_pkg;
  localparam int ADDR_HI = 35;
  localparam int ADDR_LO = 3;
  localparam int ADDR_W = ADDR_HI - ADDR_LO + 1;
  localparam int REQ_W = 5;
  localparam int SPLIT_BIT = 24;
  localparam int BPM_W = 6;
  localparam int PROBE_READY_BIT = 4;
  localparam logic [1:0] AP_RESET = 2'h3;
  localparam logic LOCK_RESET = 1'b0;
  typedef enum logic [1:0] {FSBC_IDLE, FSBC_REQ, FSBC_SUB2} fsbc_state_t;

  // Active-low lines: parity high when an even number are low
  function automatic logic fsbc_par(input logic [ADDR_W+REQ_W-1:0] v,
                                    input logic [ADDR_W+REQ_W-1:0] m);
    fsbc_par = ~(^(~v & m));
  endfunction

  // Computes both parity bits for a subphase, with swap
  function automatic logic [1:0] fsbc_ap(input logic [ADDR_W-1:0] a, input logic [REQ_W-1:0] r,
                                          input logic sub2);
    logic [ADDR_W+REQ_W-1:0] v;
    logic [ADDR_W+REQ_W-1:0] mh;
    logic hi;
    logic lo;
    v = {a, r};
    mh = {{(ADDR_HI-SPLIT_BIT+1){1'b1}}, {(SPLIT_BIT-ADDR_LO+REQ_W){1'b0}}};
    hi = fsbc_par(v, mh);
    lo = fsbc_par(v, ~mh);
    fsbc_ap = sub2 ? {hi, lo} : {lo, hi};
  endfunction
endpackage

// >>> core/fsbc_if.sv
// Front-side-bus wires shared between processor and chipset ends
interface fsbc_if;
  import fsbc_pkg::*;
  logic adsv_n;
  logic sub2;
  logic [ADDR_W-1:0] addr_n;
  logic [REQ_W-1:0] req_n;
  logic [1:0] ap_n;
  logic bus_initialization_o_cpu;
  logic bus_initialization_oe_cpu;
  logic bus_initialization_o_cs;
  logic bus_initialization_oe_cs;
  logic bnr_o_cpu;
  logic bnr_oe_cpu;
  logic bnr_o_cs;
  logic bnr_oe_cs;
  logic platform_select;
  logic [BPM_W-1:0] bpm_n;
  // Wired-low resolution of shared open-drain lines
  wire bus_initialization_n = ~((bus_initialization_oe_cpu & ~bus_initialization_o_cpu) | (bus_initialization_oe_cs & ~bus_initialization_o_cs));
  wire bnr_n = ~((bnr_oe_cpu & ~bnr_o_cpu) | (bnr_oe_cs & ~bnr_o_cs));
  modport cpu (output adsv_n, sub2, addr_n, req_n, ap_n, bus_initialization_o_cpu, bus_initialization_oe_cpu,
    bnr_o_cpu, bnr_oe_cpu, bpm_n, input platform_select, bus_initialization_n, bnr_n);
  modport cs (input adsv_n, sub2, addr_n, req_n, ap_n, bpm_n, bus_initialization_n, bnr_n,
    output bus_initialization_o_cs, bus_initialization_oe_cs, bnr_o_cs, bnr_oe_cs, platform_select);
endinterface

// >>> core/fsbc_cs.sv
// Chipset end: parity checking, stall and init driving
module fsbc_cs
  import fsbc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  fsbc_if.cs bus,
  input wire logic platform_ok,
  input wire logic busy,
  input wire logic force_init,
  output logic parity_err_r,
  output logic req_seen_r,
  output logic [ADDR_W-1:0] req_addr_r,
  output logic [REQ_W-1:0] req_type_r,
  output logic bus_initialization_event_r,
  output logic [BPM_W-1:0] bpm_r
);
  logic chk_r;
  logic init_r;

  // Expected parity for the current subphase
  wire [1:0] exp_ap = fsbc_ap(bus.addr_n, bus.req_n, bus.sub2);
  wire strobe = ~bus.adsv_n;
  wire par_bad = (chk_r | strobe) & (exp_ap != bus.ap_n);

  // Capture on strobe and check both subphases
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chk_r <= 1'b0;
      parity_err_r <= 1'b0;
      req_seen_r <= 1'b0;
      req_addr_r <= '0;
      req_type_r <= '0;
      init_r <= 1'b0;
      bus_initialization_event_r <= 1'b0;
      bpm_r <= '0;
    end else begin
      chk_r <= strobe;
      req_seen_r <= strobe;
      parity_err_r <= par_bad;
      if (strobe) begin
        req_addr_r <= ~bus.addr_n;
        req_type_r <= ~bus.req_n;
      end
      init_r <= force_init | par_bad;
      bus_initialization_event_r <= ~bus.bus_initialization_n;
      bpm_r <= ~bus.bpm_n;
    end
  end

  assign bus.platform_select = platform_ok;
  assign bus.bus_initialization_o_cs = 1'b0;
  assign bus.bus_initialization_oe_cs = init_r;
  assign bus.bnr_o_cs = 1'b0;
  assign bus.bnr_oe_cs = busy;
endmodule

// >>> test/fsbc_asserts.sv
// Checker on the shared front-side-bus wires
module fsbc_asserts
  import fsbc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic adsv_n,
  input wire logic sub2,
  input wire logic [ADDR_W-1:0] addr_n,
  input wire logic [REQ_W-1:0] req_n,
  input wire logic [1:0] ap_n,
  input wire logic bnr_n,
  input wire logic bus_initialization_n,
  input wire logic platform_select
);
  timeunit 1ns;
  timeprecision 1ps;
  // Group parities, high on an even count of low lines
  wire ph = ~^(~addr_n[32:21]);
  wire pl = ~^(~{addr_n[20:0], req_n});
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sub1_parity_a: assert property (!adsv_n |-> ap_n == {pl, ph})
    else $error("subphase one parity wrong");
  sub2_parity_a: assert property (!adsv_n && bus_initialization_n |=> sub2 && ap_n == {ph, pl})
    else $error("subphase two parity wrong");
  idle_parity_a: assert property (adsv_n && !sub2 |-> ap_n == 2'h3)
    else $error("idle parity not high");
  strobe_space_a: assert property (!adsv_n |=> adsv_n [*2])
    else $error("strobes too close");
  sub2_cause_a: assert property ($rose(sub2) |-> $past(adsv_n) == 1'b0)
    else $error("subphase two without strobe");
  sub2_end_a: assert property (sub2 |=> !sub2)
    else $error("subphase two too long");
  stall_hold_a: assert property (!bnr_n |=> adsv_n)
    else $error("issue during stall");
  platform_hold_a: assert property (!platform_select |=> adsv_n)
    else $error("issue with platform low");
endmodule

// >>> test/fsbc_tb.sv
// Testbench joining processor and chipset ends
module fsbc_tb
  import fsbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, drv_en, obs_en, req_valid, cbusy, fault, probe, plat_ok, sbusy, finit;
  logic req_ready, running, lock, seen, perr, rseen, bus_initialization_ev;
  logic [ADDR_W-1:0] req_addr, raddr;
  logic [REQ_W-1:0] req_type, rtype;
  logic [BPM_W-1:0] bpm_st, bpm_r;
  logic [3:0] in_order_queue;
  int failures = 0;
  int checks = 0;
  int cyc_n = 0;
  fsbc_if b();
  fsbc_cpu fsbc_cpu_i(.clk(clk), .rst_n(rst_n), .bus(b), .bus_initialization_drv_en(drv_en),
    .bus_initialization_obs_en(obs_en), .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr),
    .req_type(req_type), .busy(cbusy), .fault(fault), .bpm_status(bpm_st), .probe_ready(probe),
    .running(running), .bus_lock_r(lock), .ioq_count_r(in_order_queue), .bus_initialization_seen(seen));
  fsbc_cs fsbc_cs_i(.clk(clk), .rst_n(rst_n), .bus(b), .platform_ok(plat_ok), .busy(sbusy),
    .force_init(finit), .parity_err_r(perr), .req_seen_r(rseen), .req_addr_r(raddr),
    .req_type_r(rtype), .bus_initialization_event_r(bus_initialization_ev), .bpm_r(bpm_r));
  fsbc_asserts fsbc_asserts_i(.clk(clk), .rst_n(rst_n), .adsv_n(b.adsv_n), .sub2(b.sub2),
    .addr_n(b.addr_n), .req_n(b.req_n), .ap_n(b.ap_n), .bnr_n(b.bnr_n), .bus_initialization_n(b.bus_initialization_n),
    .platform_select(b.platform_select));
  task give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [ADDR_W-1:0] e, input logic [ADDR_W-1:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // One request, judged on the wires and at the chipset end
  task iss(input logic [ADDR_W-1:0] a, input logic [REQ_W-1:0] t, input logic [1:0] p1,
           input logic [1:0] p2);
    int n;
    req_addr = a;
    req_type = t;
    req_valid = 1;
    for (n = 0; n < 50 && req_ready !== 1'b1; n++) cyc(1);
    cyc(1);
    req_valid = 0;
    chk("strobe", 0, b.adsv_n);
    chk("ap1", p1, b.ap_n);
    cyc(1);
    chk("seen", 1, rseen);
    chk("addr", a, raddr);
    chk("type", t, rtype);
    chk("perr1", 0, perr);
    chk("sub2", 1, b.sub2);
    chk("ap2", p2, b.ap_n);
    cyc(1);
    chk("perr2", 0, perr);
    chk("apidle", 3, b.ap_n);
  endtask
  task t_par;
    iss('0, '0, 2'h3, 2'h3);
    iss('1, '1, 2'h3, 2'h3);
    iss(33'h0_0100_0001, 5'h04, 2'h2, 2'h1);
    iss(33'h20_0001, 5'h00, 2'h0, 2'h0);
    $display("parity test done");
  endtask
  task t_stall;
    req_addr = 33'h5;
    req_type = 5'h2;
    sbusy = 1;
    req_valid = 1;
    cyc(3);
    chk("bnr", 0, b.bnr_n);
    chk("ready", 0, req_ready);
    chk("noissue", 0, rseen);
    sbusy = 0;
    cbusy = 1;
    cyc(3);
    chk("bnrcpu", 0, b.bnr_n);
    chk("readycpu", 0, req_ready);
    cbusy = 0;
    iss(33'h5, 5'h2, 2'h1, 2'h2);
    $display("stall test done");
  endtask
  task t_init;
    logic [3:0] q;
    iss(33'h7, 5'h1, 2'h3, 2'h3);
    q = in_order_queue;
    chk("lock1", 1, lock);
    fault = 1;
    cyc(3);
    chk("bus_initialization", 0, b.bus_initialization_n);
    chk("event", 1, bus_initialization_ev);
    chk("seen", 1, seen);
    chk("lock0", 0, lock);
    chk("ioq", q, in_order_queue);
    fault = 0;
    cyc(3);
    iss(33'h9, 5'h0, 2'h3, 2'h3);
    chk("ioq2", q + 4'h1, in_order_queue);
    $display("init test done");
  endtask
  task t_mon;
    bpm_st = 6'h2b;
    probe = 1;
    cyc(3);
    chk("bpm", 6'h3b, bpm_r);
    bpm_st = 6'h15;
    probe = 0;
    cyc(3);
    chk("bpmn", 6'h3a, b.bpm_n);
    $display("monitor test done");
  endtask
  // Pending request held off while platform select low
  task t_plat;
    req_addr = 33'h5;
    req_type = 5'h2;
    plat_ok = 0;
    req_valid = 1;
    cyc(2);
    chk("run0", 0, running);
    chk("ready0", 0, req_ready);
    chk("noads", 1, b.adsv_n);
    plat_ok = 1;
    iss(33'h5, 5'h2, 2'h1, 2'h2);
    chk("run1", 1, running);
    $display("platform test done");
  endtask
  // Straps off after a second reset: own fault ignored, chipset handles init
  task t_cfg;
    rst_n = 0;
    {drv_en, obs_en} = 2'h0;
    cyc(2);
    rst_n = 1;
    cyc(2);
    fault = 1;
    cyc(3);
    chk("nodrv", 1, b.bus_initialization_n);
    fault = 0;
    finit = 1;
    cyc(3);
    chk("csinit", 0, b.bus_initialization_n);
    chk("event2", 1, bus_initialization_ev);
    chk("noseen", 0, seen);
    chk("ready2", 1, req_ready);
    finit = 0;
    cyc(3);
    chk("release", 1, b.bus_initialization_n);
    $display("strap test done");
  endtask
  // Free-running bus clock
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  // Cut a hang short
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      failures++;
      give_verdict;
    end
  end
  // Main sequence
  initial begin
    {rst_n, req_valid, cbusy, fault, probe, sbusy, finit} = '0;
    {drv_en, obs_en, plat_ok} = 3'h7;
    req_addr = '0;
    req_type = '0;
    bpm_st = '0;
    cyc(20);
    rst_n = 1;
    cyc(2);
    chk("apreset", 3, b.ap_n);
    t_par;
    t_stall;
    t_init;
    t_mon;
    t_plat;
    t_cfg;
    give_verdict;
  end
endmodule
